//--- rtl/hbpr_pkg.sv
package hbpr_pkg;
	localparam int NUM_HB   = 3;
	localparam int NUM_PWM  = 6;
	localparam int CNT_W    = 8;
	// Synchronised inputs: six PWM pins, then switching-start, switching-end.
	localparam int SYNC_W   = 12;
	localparam int IDX_PWM  = 0;
	localparam int IDX_BEG  = 6;
	localparam int IDX_END  = 9;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;
	// Bridge drive mode codes.
	localparam logic [1:0] MODE_PASSIVE_OFF = 2'h0;
	localparam logic [1:0] MODE_LS_PWM      = 2'h1;
	localparam logic [1:0] MODE_HS_PWM      = 2'h2;
	localparam logic [1:0] MODE_ACTIVE_OFF  = 2'h3;

	typedef enum logic [2:0] {
		MS_IDLE,
		MS_ON_DLY,
		MS_RISE,
		MS_OFF_DLY,
		MS_FALL
	} hbpr_meas_t;

	// Saturating increment used by every timer of the block.
	function automatic logic [CNT_W-1:0] hbpr_inc(input logic [CNT_W-1:0] v);
		hbpr_inc = (v == CNT_MAX) ? v : v + 8'h01;
	endfunction
endpackage

//--- rtl/hbpr_sync_if.sv
interface hbpr_sync_if;
	import hbpr_pkg::*;
	logic [SYNC_W-1:0] level;
	logic [SYNC_W-1:0] rise;
	logic [SYNC_W-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

//--- rtl/hbpr_sync.sv
module hbpr_sync
	import hbpr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic [SYNC_W-1:0] rawIn,
	hbpr_sync_if.src               sync
);
	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] meta_d;
	logic [SYNC_W-1:0] stable_q;
	logic [SYNC_W-1:0] stable_d;
	logic [SYNC_W-1:0] last_q;
	logic [SYNC_W-1:0] last_d;

	// Three flops per pin; edges are seen only after the second stage.
	always_comb begin
		meta_d   = rawIn;
		stable_d = meta_q;
		last_d   = stable_q;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_q   <= '0;
			stable_q <= '0;
			last_q   <= '0;
		end else begin
			meta_q   <= meta_d;
			stable_q <= stable_d;
			last_q   <= last_d;
		end
	end

	// Edge detection looks at the synchronised level only.
	assign sync.level = stable_q;
	assign sync.rise  = stable_q & ~last_q;
	assign sync.fall  = ~stable_q & last_q;
endmodule

//--- rtl/hbpr_routing.sv
// Notes on behaviour
// - Three-input mode: inputs one, three, five drive bridges.
// - Mode 00 keeps both switches passively off.
// - Mode 11 actively holds both switches off.
// - Three-input mode 01: input drives low side.
// - Three-input mode 10: high side, complementary low side.
// - Six-input mode: each switch has own input.
// - Six-input mode 01, no detection: low side active.
// - Six-input mode 10, no detection: high side active.
// - Detection enabled: roles found by detection, mode ignored.
// - Split clear: single precharge and predischarge current.
// - Split set: both phases divided in two parts.
// - Very short pulses: PWM switch treated as active.
// - Very short pulses: opposite switch stays off.
// - Report times of PWM or detected active switch.
// - Rise end missed within blank: rise zero.
// - Fall end missed within crossover: fall zero.
// - Both pulses short: all reported times zero.
// - Six-input: exclusive high input turns its switch on.
// - Early high-side edge waits for freewheel crossover.
// - PWM inputs synchronised before internal use.
module hbpr_routing
	import hbpr_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	input  wire logic [NUM_PWM-1:0]           pwmIn,
	input  wire logic [NUM_HB-1:0]            switchStartIn,
	input  wire logic [NUM_HB-1:0]            switchEndIn,
	input  wire logic                         inputCountSelect,
	input  wire logic [NUM_HB-1:0]            bridgePwmEnable,
	input  wire logic [NUM_HB-1:0][1:0]       bridgeDriveMode,
	input  wire logic                         roleDetectEnable,
	input  wire logic                         splitPhaseAdapt,
	input  wire logic [CNT_W-1:0]             freewheelCrossoverTime,
	input  wire logic [CNT_W-1:0]             activeCrossoverTime,
	input  wire logic [CNT_W-1:0]             activeBlankTime,
	input  wire logic [CNT_W-1:0]             prechargePhaseTime,
	input  wire logic [CNT_W-1:0]             predischargePhaseTime,
	output logic      [NUM_HB-1:0]            highSideSwitch,
	output logic      [NUM_HB-1:0]            lowSideSwitch,
	output logic      [NUM_HB-1:0]            activeHoldOff,
	output logic      [NUM_HB-1:0]            activeIsHigh,
	output logic      [NUM_HB-1:0]            prechargeOn,
	output logic      [NUM_HB-1:0]            prechargeSecond,
	output logic      [NUM_HB-1:0]            predischargeOn,
	output logic      [NUM_HB-1:0]            predischargeSecond,
	output logic      [NUM_HB-1:0][CNT_W-1:0] turnOnDelay,
	output logic      [NUM_HB-1:0][CNT_W-1:0] turnOffDelay,
	output logic      [NUM_HB-1:0][CNT_W-1:0] riseTime,
	output logic      [NUM_HB-1:0][CNT_W-1:0] fallTime
);
	hbpr_sync_if syncBus ();

	hbpr_sync u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.rawIn   ({switchEndIn, switchStartIn, pwmIn}),
		.sync    (syncBus)
	);

	logic [NUM_HB-1:0]            hsOn_q, hsOn_d, lsOn_q, lsOn_d;
	logic [NUM_HB-1:0]            hold_q, hold_d, actHigh_q, actHigh_d;
	logic [NUM_HB-1:0]            hsReq_q, hsReq_d, hsBlock_q, hsBlock_d;
	logic [NUM_HB-1:0]            shortOn_q, shortOn_d;
	logic [NUM_HB-1:0]            shortOff_q, shortOff_d;
	logic [NUM_HB-1:0]            detHigh_q, detHigh_d;
	logic [NUM_HB-1:0]            measPrev_q, measPrev_d;
	logic [NUM_HB-1:0]            pchg_q, pchg_d, pchg2_q, pchg2_d;
	logic [NUM_HB-1:0]            pdchg_q, pdchg_d, pdchg2_q, pdchg2_d;
	logic [NUM_HB-1:0][CNT_W-1:0] onCnt_q, onCnt_d, offCnt_q, offCnt_d;
	logic [NUM_HB-1:0][CNT_W-1:0] deadCnt_q, deadCnt_d;
	logic [NUM_HB-1:0][CNT_W-1:0] measCnt_q, measCnt_d;
	logic [NUM_HB-1:0][CNT_W-1:0] tOn_q, tOn_d, tOff_q, tOff_d;
	logic [NUM_HB-1:0][CNT_W-1:0] tRise_q, tRise_d, tFall_q, tFall_d;
	hbpr_meas_t [NUM_HB-1:0]      meas_q, meas_d;

	// Routing, timing guards, role choice and delay measurement per bridge.
	always_comb begin
		logic [1:0] m;
		logic       pwmSwHigh, inLvl, inRise, inFall, hsIn, lsIn;
		logic       hsReq, lsReq, shortAny, shortBoth, actH, measOn;
		logic       swBeg, swEnd;
		m = MODE_PASSIVE_OFF;
		{pwmSwHigh, inLvl, inRise, inFall, hsIn, lsIn} = '0;
		{hsReq, lsReq, shortAny, shortBoth, actH, measOn} = '0;
		{swBeg, swEnd} = '0;
		{hsOn_d, lsOn_d, hold_d, actHigh_d, hsReq_d, hsBlock_d} = '0;
		{shortOn_d, shortOff_d, detHigh_d, measPrev_d} = '0;
		{pchg_d, pchg2_d, pdchg_d, pdchg2_d} = '0;
		{onCnt_d, offCnt_d, deadCnt_d, measCnt_d} = '0;
		{tOn_d, tOff_d, tRise_d, tFall_d} = '0;
		meas_d = meas_q;
		for (int b = 0; b < NUM_HB; b++) begin
			m         = bridgeDriveMode[b];
			hsIn      = syncBus.level[IDX_PWM + 2*b];
			lsIn      = syncBus.level[IDX_PWM + 2*b + 1];
			swBeg     = syncBus.level[IDX_BEG + b];
			swEnd     = syncBus.level[IDX_END + b];
			pwmSwHigh = (m == MODE_HS_PWM);
			if (!inputCountSelect || pwmSwHigh) begin
				inLvl  = hsIn;
				inRise = syncBus.rise[IDX_PWM + 2*b];
				inFall = syncBus.fall[IDX_PWM + 2*b];
			end else begin
				inLvl  = lsIn;
				inRise = syncBus.rise[IDX_PWM + 2*b + 1];
				inFall = syncBus.fall[IDX_PWM + 2*b + 1];
			end

			onCnt_d[b]    = inLvl ? hbpr_inc(onCnt_q[b]) : CNT_ZERO;
			offCnt_d[b]   = inLvl ? CNT_ZERO : hbpr_inc(offCnt_q[b]);
			shortOn_d[b]  = inFall ? (onCnt_q[b] < freewheelCrossoverTime)
				: shortOn_q[b];
			shortOff_d[b] = inRise ? (offCnt_q[b] < activeCrossoverTime)
				: shortOff_q[b];
			shortAny  = shortOn_q[b] | shortOff_q[b];
			shortBoth = shortOn_q[b] & shortOff_q[b];

			hsReq = 1'b0;
			lsReq = 1'b0;
			if (!bridgePwmEnable[b] || m == MODE_PASSIVE_OFF ||
					m == MODE_ACTIVE_OFF) begin
				hsReq = 1'b0;
				lsReq = 1'b0;
			end else if (!inputCountSelect) begin
				if (m == MODE_LS_PWM) begin
					lsReq = hsIn;
				end else begin
					hsReq = hsIn;
					lsReq = !hsIn && !shortAny;
				end
			end else begin
				hsReq = hsIn && !lsIn;
				lsReq = lsIn && !hsIn;
				if (shortAny && pwmSwHigh)
					lsReq = 1'b0;
				else if (shortAny)
					hsReq = 1'b0;
			end
			hold_d[b] = (m == MODE_ACTIVE_OFF);

			// Dead-time counter restarts whenever a switch turns off.
			if ((hsOn_q[b] && !hsReq) || (lsOn_q[b] && !lsReq))
				deadCnt_d[b] = CNT_ZERO;
			else
				deadCnt_d[b] = hbpr_inc(deadCnt_q[b]);

			hsReq_d[b] = hsReq;
			if (deadCnt_q[b] >= freewheelCrossoverTime)
				hsBlock_d[b] = 1'b0;
			else if (hsReq && !hsReq_q[b] &&
					deadCnt_q[b] < activeCrossoverTime)
				hsBlock_d[b] = 1'b1;
			else
				hsBlock_d[b] = hsBlock_q[b] && hsReq;
			hsOn_d[b] = hsReq && !hsBlock_d[b];
			lsOn_d[b] = lsReq && !hsOn_d[b];

			if (roleDetectEnable && !shortAny)
				actH = detHigh_q[b];
			else
				actH = pwmSwHigh;
			actHigh_d[b] = actH;

			measOn        = actH ? hsOn_q[b] : lsOn_q[b];
			measPrev_d[b] = measOn;
			detHigh_d[b]  = detHigh_q[b];
			measCnt_d[b]  = hbpr_inc(measCnt_q[b]);
			tOn_d[b]      = tOn_q[b];
			tOff_d[b]     = tOff_q[b];
			tRise_d[b]    = tRise_q[b];
			tFall_d[b]    = tFall_q[b];
			if (measOn && !measPrev_q[b]) begin
				meas_d[b]    = MS_ON_DLY;
				measCnt_d[b] = CNT_ZERO;
			end else if (!measOn && measPrev_q[b]) begin
				meas_d[b]    = MS_OFF_DLY;
				measCnt_d[b] = CNT_ZERO;
			end else begin
				unique case (meas_q[b])
					MS_IDLE: begin
						meas_d[b] = MS_IDLE;
					end
					MS_ON_DLY: begin
						if (swBeg) begin
							tOn_d[b]     = measCnt_q[b];
							measCnt_d[b] = CNT_ZERO;
							meas_d[b]    = MS_RISE;
						end else if (measCnt_q[b] >= activeBlankTime) begin
							// No switching seen: the other switch is active.
							tOn_d[b]     = CNT_ZERO;
							tRise_d[b]   = CNT_ZERO;
							detHigh_d[b] = !actH;
							meas_d[b]    = MS_IDLE;
						end
					end
					MS_RISE: begin
						detHigh_d[b] = actH;
						if (swEnd) begin
							tRise_d[b] = measCnt_q[b];
							meas_d[b]  = MS_IDLE;
						end else if (measCnt_q[b] >= activeBlankTime) begin
							tRise_d[b] = CNT_ZERO;
							meas_d[b]  = MS_IDLE;
						end
					end
					MS_OFF_DLY: begin
						if (!swBeg) begin
							tOff_d[b]    = measCnt_q[b];
							measCnt_d[b] = CNT_ZERO;
							meas_d[b]    = MS_FALL;
						end else if (measCnt_q[b] >= activeCrossoverTime) begin
							tOff_d[b]  = CNT_ZERO;
							tFall_d[b] = CNT_ZERO;
							meas_d[b]  = MS_IDLE;
						end
					end
					MS_FALL: begin
						if (!swEnd) begin
							tFall_d[b] = measCnt_q[b];
							meas_d[b]  = MS_IDLE;
						end else if (measCnt_q[b] >= activeCrossoverTime) begin
							tFall_d[b] = CNT_ZERO;
							meas_d[b]  = MS_IDLE;
						end
					end
				endcase
			end
			if (shortBoth) begin
				tOn_d[b]   = CNT_ZERO;
				tOff_d[b]  = CNT_ZERO;
				tRise_d[b] = CNT_ZERO;
				tFall_d[b] = CNT_ZERO;
			end

			pchg_d[b]   = (meas_q[b] == MS_ON_DLY) &&
				(measCnt_q[b] < prechargePhaseTime);
			pchg2_d[b]  = pchg_d[b] && splitPhaseAdapt &&
				(measCnt_q[b] >= (prechargePhaseTime >> 1));
			pdchg_d[b]  = (meas_q[b] == MS_OFF_DLY) &&
				(measCnt_q[b] < predischargePhaseTime);
			pdchg2_d[b] = pdchg_d[b] && splitPhaseAdapt &&
				(measCnt_q[b] >= (predischargePhaseTime >> 1));
		end
	end

	// State registers; every output below is one of these.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			{hsOn_q, lsOn_q, hold_q, actHigh_q, hsReq_q, hsBlock_q} <= '0;
			{shortOn_q, shortOff_q, detHigh_q, measPrev_q} <= '0;
			{pchg_q, pchg2_q, pdchg_q, pdchg2_q} <= '0;
			{onCnt_q, offCnt_q, deadCnt_q, measCnt_q} <= '0;
			{tOn_q, tOff_q, tRise_q, tFall_q} <= '0;
			for (int b = 0; b < NUM_HB; b++) begin
				meas_q[b] <= MS_IDLE;
			end
		end else begin
			hsOn_q     <= hsOn_d;
			lsOn_q     <= lsOn_d;
			hold_q     <= hold_d;
			actHigh_q  <= actHigh_d;
			hsReq_q    <= hsReq_d;
			hsBlock_q  <= hsBlock_d;
			shortOn_q  <= shortOn_d;
			shortOff_q <= shortOff_d;
			detHigh_q  <= detHigh_d;
			measPrev_q <= measPrev_d;
			pchg_q     <= pchg_d;
			pchg2_q    <= pchg2_d;
			pdchg_q    <= pdchg_d;
			pdchg2_q   <= pdchg2_d;
			onCnt_q    <= onCnt_d;
			offCnt_q   <= offCnt_d;
			deadCnt_q  <= deadCnt_d;
			measCnt_q  <= measCnt_d;
			tOn_q      <= tOn_d;
			tOff_q     <= tOff_d;
			tRise_q    <= tRise_d;
			tFall_q    <= tFall_d;
			meas_q     <= meas_d;
		end
	end

	// Outputs come straight from the state registers.
	assign highSideSwitch     = hsOn_q;
	assign lowSideSwitch      = lsOn_q;
	assign activeHoldOff      = hold_q;
	assign activeIsHigh       = actHigh_q;
	assign prechargeOn        = pchg_q;
	assign prechargeSecond    = pchg2_q;
	assign predischargeOn     = pdchg_q;
	assign predischargeSecond = pdchg2_q;
	assign turnOnDelay        = tOn_q;
	assign turnOffDelay       = tOff_q;
	assign riseTime           = tRise_q;
	assign fallTime           = tFall_q;
endmodule

//--- bench/hbpr_mcu.sv
module hbpr_mcu
	import hbpr_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               run,
	input  wire logic [CNT_W-1:0]   onCyc,
	input  wire logic [CNT_W-1:0]   offCyc,
	input  wire logic [NUM_PWM-1:0] pattern,
	output logic      [NUM_PWM-1:0] pwm
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [CNT_W-1:0] cnt = CNT_ZERO;
	initial pwm = '0;
	// Pins move just after an edge: a static pattern, or a timer on pin 0.
	always @(posedge clk) begin
		if (!run) begin
			pwm <= pattern;
			cnt <= CNT_ZERO;
		end else if (cnt >= (pwm[0] ? onCyc : offCyc) - 8'h01) begin
			pwm[0] <= !pwm[0];
			cnt <= CNT_ZERO;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

//--- bench/hbpr_routing_sva.sv
module hbpr_routing_sva
	import hbpr_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire logic [NUM_PWM-1:0]     pwmIn,
	input wire logic                   inputCountSelect,
	input wire logic [NUM_HB-1:0]      bridgePwmEnable,
	input wire logic [NUM_HB-1:0][1:0] bridgeDriveMode,
	input wire logic                   splitPhaseAdapt,
	input wire logic [CNT_W-1:0]       freewheelCrossoverTime,
	input wire logic [CNT_W-1:0]       activeCrossoverTime,
	input wire logic [NUM_HB-1:0]      highSideSwitch,
	input wire logic [NUM_HB-1:0]      lowSideSwitch,
	input wire logic [NUM_HB-1:0]      activeHoldOff,
	input wire logic [NUM_HB-1:0]      prechargeSecond,
	input wire logic [NUM_HB-1:0]      predischargeSecond
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic       e0;
	logic [1:0] m0;
	// Plain routing holds only while no crossover time can block an edge.
	assign e0 = bridgePwmEnable[0]
		&& (freewheelCrossoverTime | activeCrossoverTime) == CNT_ZERO;
	assign m0 = bridgeDriveMode[0];

	passive_off_a: assert property (
		m0 == MODE_PASSIVE_OFF |=> !highSideSwitch[0] && !lowSideSwitch[0]
		&& !activeHoldOff[0]) else $error("mode 00 bridge not off");
	active_off_a: assert property (
		m0 == MODE_ACTIVE_OFF |=> activeHoldOff[0] && !highSideSwitch[0]
		&& !lowSideSwitch[0]) else $error("mode 11 bridge not held off");
	never_both_a: assert property (
		!(|(highSideSwitch & lowSideSwitch))) else $error("both switches on");
	disabled_off_a: assert property (
		!bridgePwmEnable[0] |=> !highSideSwitch[0] && !lowSideSwitch[0])
		else $error("disabled bridge drives");
	ls_follow_a: assert property (
		(!inputCountSelect && e0 && m0 == MODE_LS_PWM)[*4] |->
		lowSideSwitch[0] == $past(pwmIn[0], 3) && !highSideSwitch[0])
		else $error("mode 01 low side wrong");
	hs_follow_a: assert property (
		(!inputCountSelect && e0 && m0 == MODE_HS_PWM)[*4] |->
		highSideSwitch[0] == $past(pwmIn[0], 3)
		&& lowSideSwitch[0] != $past(pwmIn[0], 3))
		else $error("mode 10 switches wrong");
	six_pins_a: assert property (
		(inputCountSelect && e0 && m0 inside {2'h1, 2'h2})[*4] |->
		lowSideSwitch[0] == ($past(pwmIn[1], 3) && !$past(pwmIn[0], 3))
		&& highSideSwitch[0] == ($past(pwmIn[0], 3) && !$past(pwmIn[1], 3)))
		else $error("six-input switches wrong");
	third_bridge_a: assert property (
		(!inputCountSelect && bridgePwmEnable[2]
		&& bridgeDriveMode[2] == MODE_LS_PWM && e0)[*4] |->
		lowSideSwitch[2] == $past(pwmIn[4], 3))
		else $error("bridge 3 not on pin 5");
	split_clear_a: assert property (
		(!splitPhaseAdapt)[*3] |-> !(|prechargeSecond)
		&& !(|predischargeSecond)) else $error("split phase while cleared");
endmodule

bind hbpr_routing hbpr_routing_sva i_sva (.*);

//--- bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import hbpr_pkg::*;
	logic                         clk = 1'b0;
	logic                         reset_n = 1'b0;
	logic                         run = 1'b0;
	logic                         inputCountSelect = 1'b0;
	logic                         splitPhaseAdapt = 1'b0;
	logic                         roleDetectEnable = 1'b0;
	logic [NUM_PWM-1:0]           pwmIn;
	logic [NUM_PWM-1:0]           pattern = '0;
	logic [NUM_HB-1:0]            bridgePwmEnable = '0;
	logic [NUM_HB-1:0][1:0]       bridgeDriveMode = '0;
	logic [NUM_HB-1:0]            switchStartIn, switchEndIn;
	logic [NUM_HB-1:0]            highSideSwitch, lowSideSwitch;
	logic [NUM_HB-1:0]            activeHoldOff, activeIsHigh;
	logic [NUM_HB-1:0]            prechargeOn, prechargeSecond;
	logic [NUM_HB-1:0]            predischargeOn, predischargeSecond;
	logic [NUM_HB-1:0][CNT_W-1:0] turnOnDelay, turnOffDelay;
	logic [NUM_HB-1:0][CNT_W-1:0] riseTime, fallTime;
	logic [CNT_W-1:0]             freewheelCrossoverTime = '0;
	logic [CNT_W-1:0]             activeCrossoverTime = '0;
	logic [CNT_W-1:0]             activeBlankTime = 8'h32;
	logic [CNT_W-1:0]             prechargePhaseTime = 8'h04;
	logic [CNT_W-1:0]             predischargePhaseTime = 8'h04;
	logic [CNT_W-1:0]             onCyc = 8'h28, offCyc = 8'h28;
	logic [15:0][NUM_HB-1:0]      fb = '0;
	logic [11:0]                  qSw[$];
	logic [3:0]                   qRep[$];
	logic [1:0]                   qSplit[$];
	logic [1:0]                   seenSplit = '0;
	int                           n_mismatch = 0, n_checks = 0;

	hbpr_routing i_dut (.*);
	hbpr_mcu i_mcu (.clk, .run, .onCyc, .offCyc, .pattern, .pwm(pwmIn));

	always #2 clk = !clk;
	// Power stage: switching starts 2 cycles and ends 16 cycles after command.
	always @(posedge clk) fb <= {fb[14:0], highSideSwitch};
	assign switchStartIn = fb[1];
	assign switchEndIn = fb[15];

	// Switch levels per bridge from mode, enable and pin pattern.
	function automatic logic [11:0] expSw(logic s, logic [2:0] en,
			logic [2:0][1:0] md, logic [5:0] p);
		logic [11:0] r;
		r = '0;
		for (int b = 0; b < 3; b++) begin
			r[9+b] = md[b] == MODE_HS_PWM;
			r[6+b] = md[b] == MODE_ACTIVE_OFF;
			if (en[b] && md[b] inside {MODE_LS_PWM, MODE_HS_PWM}) begin
				if (s)
					{r[3+b], r[b]} = {p[2*b+1] & !p[2*b], p[2*b] & !p[2*b+1]};
				else if (md[b] == MODE_HS_PWM)
					{r[3+b], r[b]} = {!p[2*b], p[2*b]};
				else
					r[3+b] = p[2*b];
			end
		end
		return r;
	endfunction

	task automatic fail(string m);
		n_mismatch++;
		$display("Error %0t: %s", $time, m);
	endtask

	task automatic cmpSw(logic [11:0] e);
		n_checks++;
		if ({activeIsHigh, activeHoldOff, lowSideSwitch,
				highSideSwitch} !== e)
			fail("switch outputs differ");
	endtask

	task automatic cmpSplit(logic [1:0] e);
		n_checks++;
		if (seenSplit !== e)
			fail("split phase indicators differ");
	endtask

	task automatic cmpRep(logic [3:0] e);
		n_checks++;
		if ({|turnOnDelay[0], |turnOffDelay[0], |riseTime[0],
				|fallTime[0]} !== e)
			fail("report zero pattern differs");
	endtask

	// Checks the oldest note once the outputs have settled.
	// Second phase parts seen since the last note are gathered here too.
	always @(negedge clk) begin
		seenSplit = seenSplit | {prechargeSecond[0], predischargeSecond[0]};
		if (qSw.size() > 0) begin
			cmpSw(qSw.pop_front());
			seenSplit = '0;
		end
		if (qRep.size() > 0)
			cmpRep(qRep.pop_front());
		if (qSplit.size() > 0) begin
			cmpSplit(qSplit.pop_front());
			seenSplit = '0;
		end
	end

	// Runs a timed PWM on bridge 1 and notes which reports are nonzero.
	// The phases are shorter than the switching delay, so a split shows.
	task automatic measure(logic [7:0] fw, act, bl, on, off, logic [3:0] e,
			logic sp);
		freewheelCrossoverTime <= fw;
		activeCrossoverTime <= act;
		activeBlankTime <= bl;
		onCyc <= on;
		offCyc <= off;
		splitPhaseAdapt <= sp;
		run <= 1'b1;
		repeat (400) @(posedge clk);
		qRep.push_back(e);
		qSplit.push_back({sp, sp});
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		fail("timeout");
		test_done();
	end

	initial begin
		logic [2:0][1:0] md;
		logic [2:0]      en;
		logic [5:0]      p;
		void'($urandom(72));
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 48; i++) begin
			md = {2'(i + 2), 2'(i + 1), 2'(i)};
			en = 3'($urandom) | 3'(i[3]);
			p = 6'($urandom);
			inputCountSelect <= i[2];
			bridgeDriveMode <= md;
			bridgePwmEnable <= en;
			splitPhaseAdapt <= 1'($urandom);
			pattern <= p;
			repeat (5) @(posedge clk);
			qSw.push_back(expSw(i[2], en, md, p));
		end
		inputCountSelect <= 1'b0;
		bridgePwmEnable <= 3'h1;
		bridgeDriveMode <= {2'h0, 2'h0, MODE_HS_PWM};
		measure(8'h02, 8'h1e, 8'h32, 8'h28, 8'h28, 4'hf, 1'b1);
		measure(8'h02, 8'h1e, 8'h08, 8'h28, 8'h28, 4'hd, 1'b0);
		measure(8'h02, 8'h08, 8'h32, 8'h28, 8'h28, 4'he, 1'b0);
		measure(8'h14, 8'h14, 8'h32, 8'h02, 8'h02, 4'h0, 1'b0);
		// A reset in mid-run clears every command and every report.
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		qSw.push_back('0);
		qRep.push_back('0);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule
